// File: rtl/ochps_pkg.sv
// Purpose: Shared constants and types for the output clock halt and phase step block
// Assumes: 32-bit APB with byte addresses, one aligned word per register
// Notes: Register contents sit in the low byte, upper bits read as zero
package ochps_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam int unsigned ADDR_W = 12;
    localparam logic [11:0] HALT_CTRL_OFS = 12'h208;
    localparam logic [11:0] PHASE_OFS_OFS = 12'h20c;
    localparam logic [11:0] CFG_OFS = 12'h210;
    localparam logic [11:0] SLOW_DIV_OFS = 12'h214;
    localparam logic [11:0] STATUS_OFS = 12'h218;
    localparam logic [7:0] REG_RESET = 8'h00;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int unsigned HALT_BIT_POS = 7;
    localparam int unsigned SRC_LSB = 2;
    localparam int unsigned MODE_LSB = 0;
    localparam int unsigned ST_ADJUST_FLAG_A_POS = 0;
    localparam int unsigned ST_DONE_POS = 1;
    localparam int unsigned ST_HALTED_POS = 2;

    // ------------------------------------------------------------
    // Codes and timing
    // ------------------------------------------------------------
    localparam logic [3:0] SRC_SW_BIT = 4'h0;
    localparam logic [3:0] SRC_ARMING = 4'h1;
    localparam logic [3:0] SRC_GPIO0 = 4'h8;
    localparam logic [3:0] SRC_GPIO3 = 4'hb;
    localparam int unsigned HALF_CYCLES_DEF = 4;

    typedef enum logic [1:0] {
        MODE_NEVER = 2'h0,
        MODE_HIGH = 2'h1,
        MODE_LOW = 2'h2,
        MODE_UNUSED = 2'h3
    } ochps_mode_t;

    typedef enum logic [2:0] {
        FMT_OFF = 3'h0, FMT_CML_STD = 3'h1, FMT_CML_NAR = 3'h2, FMT_HSTL = 3'h3,
        FMT_TWO_INPH = 3'h4, FMT_NEG_ONLY = 3'h5, FMT_POS_ONLY = 3'h6, FMT_TWO_INV = 3'h7
    } ochps_fmt_t;

    // Configuration register layout, bit 7 first
    typedef struct packed {
        logic phase_step_enable;
        logic neg_pin_slow_divider;
        logic clock_path_invert;
        logic tristate_when_halted;
        logic auto_mute_enable;
        ochps_fmt_t out_signal_format;
    } ochps_cfg_t;

    // Output pin drive, enables active low
    typedef struct packed {
        logic pos_o;
        logic pos_oe_n;
        logic neg_o;
        logic neg_oe_n;
    } ochps_pins_t;
endpackage : ochps_pkg

// File: rtl/ochps_top.sv
// Purpose: Output clock generator with halt/resume and signed half-period phase step
// Assumes: All inputs synchronous to pclk; pclk at 100 MHz
// Notes: Fast divider clock is modelled as a pclk divider of HALF_CYCLES per half period
module ochps_top #(
    parameter int unsigned HALF_CYCLES = ochps_pkg::HALF_CYCLES_DEF
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic phase_adjust_event,
    input wire logic chosen_reference,
    input wire logic [3:0] gpio,
    output ochps_pkg::ochps_pins_t out_pins
);
    // ------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------
    localparam int unsigned CW = $clog2(2 * HALF_CYCLES) + 1;
    localparam logic [CW-1:0] HALF_LD = CW'(HALF_CYCLES);
    localparam logic [CW-1:0] LONG_LD = CW'(2 * HALF_CYCLES);
    localparam logic [CW-1:0] SHORT_LD = CW'(HALF_CYCLES / 2);
    localparam logic [CW-1:0] CNT_ONE = CW'(1);

    generate
        if (HALF_CYCLES < 4 || HALF_CYCLES % 2 != 0) begin : g_bad
            $error("HALF_CYCLES must be even and at least 4");
        end
    endgenerate

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [7:0] halt_ctrl_q;
    logic [7:0] phase_off_q;
    ochps_pkg::ochps_cfg_t cfg_q;
    logic [7:0] slow_div_q;
    logic adjust_flag_a_q;
    logic done_q;
    logic [31:0] prdata_q;
    logic pslverr_q;
    logic acc_wr;
    logic setup;
    logic hit;
    logic [7:0] rd_byte;

    logic halt_bit;
    logic [3:0] src;
    ochps_pkg::ochps_mode_t mode;
    assign halt_bit = halt_ctrl_q[ochps_pkg::HALT_BIT_POS];
    assign src = halt_ctrl_q[ochps_pkg::SRC_LSB +: 4];
    assign mode = ochps_pkg::ochps_mode_t'(halt_ctrl_q[ochps_pkg::MODE_LSB +: 2]);

    typedef enum logic {ST_RUN = 1'b0, ST_HALT = 1'b1} ochps_st_t;
    ochps_st_t st_q;
    ochps_st_t st_d;
    logic hold_q;
    logic hold_d;

    assign acc_wr = psel && penable && pwrite;
    assign setup = psel && !penable;
    assign pready = 1'b1;
    assign prdata = prdata_q;
    assign pslverr = pslverr_q;

    always_comb begin
        hit = 1'b1;
        unique case (paddr)
            ochps_pkg::HALT_CTRL_OFS: rd_byte = halt_ctrl_q;
            ochps_pkg::PHASE_OFS_OFS: rd_byte = phase_off_q;
            ochps_pkg::CFG_OFS: rd_byte = cfg_q;
            ochps_pkg::SLOW_DIV_OFS: rd_byte = slow_div_q;
            ochps_pkg::STATUS_OFS: rd_byte = {5'h00, st_q == ST_HALT, done_q, adjust_flag_a_q};
            default: begin
                rd_byte = 8'h00;
                hit = 1'b0;
            end
        endcase
    end

    // Read data and error captured in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else if (setup) begin
            prdata_q <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
            pslverr_q <= !hit;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            halt_ctrl_q <= ochps_pkg::REG_RESET;
            phase_off_q <= ochps_pkg::REG_RESET;
            cfg_q <= ochps_pkg::ochps_cfg_t'(ochps_pkg::REG_RESET);
            slow_div_q <= ochps_pkg::REG_RESET;
        end else if (acc_wr) begin
            unique case (paddr)
                ochps_pkg::HALT_CTRL_OFS: halt_ctrl_q <= pwdata[7:0];
                ochps_pkg::PHASE_OFS_OFS: phase_off_q <= pwdata[7:0];
                ochps_pkg::CFG_OFS: cfg_q <= ochps_pkg::ochps_cfg_t'(pwdata[7:0]);
                ochps_pkg::SLOW_DIV_OFS: slow_div_q <= pwdata[7:0];
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Phase adjustment
    // ------------------------------------------------------------
    logic [CW-1:0] cnt_q;
    logic gen_q;
    logic [6:0] stretch_q;
    logic [8:0] shorten_q;
    logic busy_q;
    logic bound;
    logic rise;
    logic fall;
    logic take_evt;
    logic done_set;
    logic st_wr;

    assign bound = cnt_q == CNT_ONE;
    assign rise = bound && !gen_q;
    assign fall = bound && gen_q;
    assign take_evt = adjust_flag_a_q && phase_adjust_event;
    assign done_set = busy_q && stretch_q == 7'h00 && shorten_q == 9'h000;
    assign st_wr = acc_wr && paddr == ochps_pkg::STATUS_OFS;

    // Arm by software, disarm on the event so it is consumed once
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            adjust_flag_a_q <= 1'b0;
        end else if (take_evt) begin
            adjust_flag_a_q <= 1'b0;
        end else if (st_wr && pwdata[ochps_pkg::ST_ADJUST_FLAG_A_POS]) begin
            adjust_flag_a_q <= 1'b1;
        end
    end

    // Done latch, write one to clear, a new completion wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_q <= 1'b0;
        end else if (done_set) begin
            done_q <= 1'b1;
        end else if (st_wr && pwdata[ochps_pkg::ST_DONE_POS]) begin
            done_q <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_q <= 1'b0;
        end else if (take_evt) begin
            busy_q <= 1'b1;
        end else if (done_set) begin
            busy_q <= 1'b0;
        end
    end

    // Pending steps: stretch by whole half periods, shorten by half a half period twice per step
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stretch_q <= 7'h00;
            shorten_q <= 9'h000;
        end else if (take_evt) begin
            if (!cfg_q.phase_step_enable) begin
                stretch_q <= 7'h00;
                shorten_q <= 9'h000;
            end else if (!phase_off_q[7]) begin
                stretch_q <= phase_off_q[6:0];
                shorten_q <= 9'h000;
            end else begin
                stretch_q <= 7'h00;
                shorten_q <= {1'b0, (~phase_off_q) + 8'h01} << 1;
            end
        end else if (bound) begin
            if (stretch_q != 7'h00) begin
                stretch_q <= stretch_q - 7'h01;
            end else if (shorten_q != 9'h000) begin
                shorten_q <= shorten_q - 9'h001;
            end
        end
    end

    // Fast divider half-period timer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= HALF_LD;
            gen_q <= 1'b0;
        end else if (bound) begin
            gen_q <= !gen_q;
            if (stretch_q != 7'h00) begin
                cnt_q <= LONG_LD;
            end else if (shorten_q != 9'h000) begin
                cnt_q <= SHORT_LD;
            end else begin
                cnt_q <= HALF_LD;
            end
        end else begin
            cnt_q <= cnt_q - CNT_ONE;
        end
    end

    // ------------------------------------------------------------
    // Slow divider
    // ------------------------------------------------------------
    logic [7:0] sd_cnt_q;
    logic sd_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sd_cnt_q <= 8'h00;
            sd_q <= 1'b0;
        end else if (slow_div_q == 8'h00) begin
            sd_cnt_q <= 8'h00;
            sd_q <= gen_q;
        end else if (rise) begin
            sd_cnt_q <= (sd_cnt_q >= slow_div_q) ? 8'h00 : sd_cnt_q + 8'h01;
            sd_q <= (sd_cnt_q >= slow_div_q) || (sd_cnt_q < (slow_div_q >> 1));
        end
    end

    // ------------------------------------------------------------
    // Halt source and state
    // ------------------------------------------------------------
    logic arm_halt_q;
    logic adjust_flag_a_d1_q;
    logic done_d1_q;
    logic halt_sel;
    logic halt_req_q;
    logic mode_act;

    assign mode_act = mode == ochps_pkg::MODE_HIGH || mode == ochps_pkg::MODE_LOW;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            adjust_flag_a_d1_q <= 1'b0;
            done_d1_q <= 1'b0;
            arm_halt_q <= 1'b0;
        end else begin
            adjust_flag_a_d1_q <= adjust_flag_a_q;
            done_d1_q <= done_q;
            if (done_q && !done_d1_q) begin
                arm_halt_q <= 1'b0;
            end else if (adjust_flag_a_q && !adjust_flag_a_d1_q) begin
                arm_halt_q <= 1'b1;
            end
        end
    end

    always_comb begin
        if (src == ochps_pkg::SRC_SW_BIT) begin
            halt_sel = halt_bit;
        end else if (src == ochps_pkg::SRC_ARMING) begin
            halt_sel = arm_halt_q;
        end else if (src >= ochps_pkg::SRC_GPIO0 && src <= ochps_pkg::SRC_GPIO3) begin
            halt_sel = gpio[src[1:0]];
        end else begin
            halt_sel = 1'b0;
        end
    end

    // Registered request; edges below make halts land between whole pulses
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            halt_req_q <= 1'b0;
        end else begin
            halt_req_q <= mode_act && (halt_sel || (cfg_q.auto_mute_enable && !chosen_reference));
        end
    end

    always_comb begin
        st_d = st_q;
        hold_d = hold_q;
        unique case (st_q)
            ST_RUN: begin
                if (halt_req_q && mode == ochps_pkg::MODE_HIGH && rise) begin
                    st_d = ST_HALT;
                    hold_d = 1'b1;
                end else if (halt_req_q && mode == ochps_pkg::MODE_LOW && fall) begin
                    st_d = ST_HALT;
                    hold_d = 1'b0;
                end
            end
            ST_HALT: begin
                if (!halt_req_q && ((hold_q && fall) || (!hold_q && rise))) begin
                    st_d = ST_RUN;
                end
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= ST_RUN;
            hold_q <= 1'b0;
        end else begin
            st_q <= st_d;
            hold_q <= hold_d;
        end
    end

    // ------------------------------------------------------------
    // Pin mapping
    // ------------------------------------------------------------
    logic lvl;
    logic halted;
    ochps_pkg::ochps_pins_t pins_d;
    ochps_pkg::ochps_pins_t pins_q;

    assign halted = st_q == ST_HALT;
    assign lvl = (halted ? hold_q : gen_q) ^ cfg_q.clock_path_invert;

    always_comb begin
        pins_d = '{pos_o: 1'b0, pos_oe_n: 1'b1, neg_o: 1'b0, neg_oe_n: 1'b1};
        unique case (cfg_q.out_signal_format)
            ochps_pkg::FMT_OFF: ;
            ochps_pkg::FMT_CML_STD, ochps_pkg::FMT_CML_NAR: begin
                pins_d = '{pos_o: lvl, pos_oe_n: 1'b0, neg_o: !lvl, neg_oe_n: 1'b0};
            end
            ochps_pkg::FMT_HSTL, ochps_pkg::FMT_TWO_INV: begin
                pins_d = '{pos_o: !lvl, pos_oe_n: 1'b0, neg_o: lvl, neg_oe_n: 1'b0};
            end
            ochps_pkg::FMT_TWO_INPH: begin
                pins_d = '{pos_o: lvl, pos_oe_n: 1'b0, neg_o: lvl, neg_oe_n: 1'b0};
            end
            ochps_pkg::FMT_NEG_ONLY: begin
                pins_d.neg_o = lvl;
                pins_d.neg_oe_n = 1'b0;
            end
            ochps_pkg::FMT_POS_ONLY: begin
                pins_d.pos_o = lvl;
                pins_d.pos_oe_n = 1'b0;
            end
        endcase
        if (cfg_q.neg_pin_slow_divider && cfg_q.out_signal_format != ochps_pkg::FMT_OFF) begin
            pins_d.neg_o = sd_q;
            pins_d.neg_oe_n = 1'b0;
        end
        if (halted && cfg_q.tristate_when_halted) begin
            pins_d = '{pos_o: 1'b0, pos_oe_n: 1'b1, neg_o: 1'b0, neg_oe_n: 1'b1};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pins_q <= '{pos_o: 1'b0, pos_oe_n: 1'b1, neg_o: 1'b0, neg_oe_n: 1'b1};
        end else begin
            pins_q <= pins_d;
        end
    end

    assign out_pins = pins_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence s_evt_taken;
        adjust_flag_a_q && phase_adjust_event;
    endsequence

    property p_step_ignored;
        @(posedge pclk) disable iff (!presetn)
        s_evt_taken and !cfg_q.phase_step_enable |=> stretch_q == 7'h00 && shorten_q == 9'h000;
    endproperty
    a_step_ignored: assert property (p_step_ignored) else $error("offset used while stepping disabled");

    property p_once;
        @(posedge pclk) disable iff (!presetn)
        s_evt_taken |=> !adjust_flag_a_q ##1 !(adjust_flag_a_q && !adjust_flag_a_d1_q && !$past(st_wr));
    endproperty
    a_once: assert property (p_once) else $error("adjustment not consumed once");

    property p_delay_load;
        @(posedge pclk) disable iff (!presetn)
        s_evt_taken and cfg_q.phase_step_enable and !phase_off_q[7] |=> stretch_q == $past(phase_off_q[6:0]);
    endproperty
    a_delay_load: assert property (p_delay_load) else $error("positive offset not loaded");

    property p_adv_load;
        @(posedge pclk) disable iff (!presetn)
        s_evt_taken and cfg_q.phase_step_enable and phase_off_q[7]
            |=> shorten_q == 9'(2 * (9'h100 - {1'b0, $past(phase_off_q)}));
    endproperty
    a_adv_load: assert property (p_adv_load) else $error("negative offset wrong");

    property p_never;
        @(posedge pclk) disable iff (!presetn)
        !mode_act && st_q == ST_RUN |=> st_q == ST_RUN;
    endproperty
    a_never: assert property (p_never) else $error("halt with mode never");

    property p_halt_high;
        @(posedge pclk) disable iff (!presetn)
        $rose(halted) && hold_q |-> $past(rise && halt_req_q) && gen_q;
    endproperty
    a_halt_high: assert property (p_halt_high) else $error("halt high not after rise");

    property p_halt_low;
        @(posedge pclk) disable iff (!presetn)
        $rose(halted) && !hold_q |-> $past(fall && halt_req_q) && !gen_q;
    endproperty
    a_halt_low: assert property (p_halt_low) else $error("halt low not after fall");

    property p_sw_bit;
        @(posedge pclk) disable iff (!presetn)
        src == ochps_pkg::SRC_SW_BIT && mode_act && halt_bit && !cfg_q.auto_mute_enable
            ##1 src == ochps_pkg::SRC_SW_BIT && mode_act |-> halt_req_q;
    endproperty
    a_sw_bit: assert property (p_sw_bit) else $error("software halt not requested");

    property p_tristate;
        @(posedge pclk) disable iff (!presetn)
        halted && cfg_q.tristate_when_halted |=> out_pins.pos_oe_n && out_pins.neg_oe_n;
    endproperty
    a_tristate: assert property (p_tristate) else $error("pins driven while halted");

    property p_slow;
        @(posedge pclk) disable iff (!presetn)
        !(halted && cfg_q.tristate_when_halted) && cfg_q.neg_pin_slow_divider && cfg_q.out_signal_format != 3'h0
            |=> !out_pins.neg_oe_n && out_pins.neg_o == $past(sd_q);
    endproperty
    a_slow: assert property (p_slow) else $error("slow clock not on negative pin");
endmodule : ochps_top

// File: tb/ochps_load.sv
// Purpose: Clock load model on the output pins
// Assumes: Pins sampled on pclk; a floating pin shows a level that changes every cycle
// Notes: Counts rises of the positive pin and tracks its shortest pulse while watched
module ochps_load (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic watch,
    input wire ochps_pkg::ochps_pins_t pins,
    output logic pos_lvl,
    output logic neg_lvl,
    output int unsigned rises,
    output int unsigned last_rise,
    output int unsigned min_run
);
    timeunit 1ns;
    timeprecision 1ps;
    int unsigned cyc;
    int unsigned run;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {pos_lvl, neg_lvl} <= 2'h0;
            {cyc, run, rises, last_rise} <= '0;
            min_run <= 255;
        end else begin
            cyc <= cyc + 1;
            pos_lvl <= pins.pos_oe_n ? ~pos_lvl : pins.pos_o;
            neg_lvl <= pins.neg_oe_n ? ~neg_lvl : pins.neg_o;
            run <= pins.pos_oe_n ? 0 : (pins.pos_o == pos_lvl) ? run + 1 : 1;
            if (!pins.pos_oe_n && pins.pos_o != pos_lvl && run > 0 && run < min_run && watch) begin
                min_run <= run;
            end
            if (!pins.pos_oe_n && pins.pos_o && !pos_lvl) begin
                rises <= rises + 1;
                last_rise <= cyc;
            end
        end
    end
endmodule : ochps_load

// File: tb/ochps_top_tb.sv
// Purpose: Self-checking bench for the output clock halt and phase step block
// Assumes: Zero-wait APB slave, fixed seed
// Notes: HC sets the fast clock half period in pclk cycles, equal to the default
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin failures++; \
    $display("Error %s expected %0h seen %0h", n, e, g); end end
module ochps_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int HC = 4;
    localparam int LIMIT = 60000;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata, rdat, d;
    logic pready, pslverr, rerr, pos_lvl, neg_lvl;
    logic phase_adjust_event = 1'b0;
    logic chosen_reference = 1'b1;
    logic [3:0] gpio = 4'h0;
    logic watch = 1'b0;
    ochps_pkg::ochps_pins_t out_pins;
    int unsigned rises, last_rise, min_run;
    int unsigned cycles = 0;
    int failures = 0;
    int samples_checked = 0;
    ochps_top #(.HALF_CYCLES(HC)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .phase_adjust_event(phase_adjust_event), .chosen_reference(chosen_reference), .gpio(gpio),
        .out_pins(out_pins));
    ochps_load load (.pclk(pclk), .presetn(presetn), .watch(watch), .pins(out_pins), .pos_lvl(pos_lvl),
        .neg_lvl(neg_lvl), .rises(rises), .last_rise(last_rise), .min_run(min_run));
    initial begin
        forever #5 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            failures++;
            complete_run();
        end
    end
    task automatic complete_run();
        if (failures == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : complete_run
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic pulse();
        phase_adjust_event <= 1'b1;
        @(posedge pclk);
        phase_adjust_event <= 1'b0;
    endtask : pulse
    function automatic int shift(input int k, input bit en, input bit arm);
        return (en && arm) ? k * HC : 0;
    endfunction : shift
    // ----------------------------
    // Halt and pin checks
    // ----------------------------
    task automatic halt_chk(input logic [7:0] ctl, input logic [7:0] cfg, input logic eh, input logic lv);
        int unsigned r0;
        logic nf, chg, sp, sn, tri_on;
        apb(1'b1, ochps_pkg::CFG_OFS, cfg);
        apb(1'b1, ochps_pkg::HALT_CTRL_OFS, ctl);
        repeat (6 * HC) @(posedge pclk);
        r0 = rises;
        nf = out_pins.neg_o;
        chg = 1'b0;
        repeat (4 * HC) begin
            @(posedge pclk);
            if (out_pins.neg_o !== nf) chg = 1'b1;
        end
        sp = cfg[2:0] inside {3'h1, 3'h2, 3'h4, 3'h6};
        sn = cfg[2:0] inside {3'h3, 3'h4, 3'h5, 3'h7} && !cfg[6];
        tri_on = eh && cfg[4];
        apb(1'b0, ochps_pkg::STATUS_OFS, 32'h0);
        `CHK("halted", eh, rdat[ochps_pkg::ST_HALTED_POS])
        if (tri_on) `CHK("float", 2'b11, {out_pins.pos_oe_n, out_pins.neg_oe_n})
        if (!tri_on && eh && sp) `CHK("pos level", lv, out_pins.pos_o)
        if (!tri_on && eh && sn) `CHK("neg level", lv, out_pins.neg_o)
        if (!tri_on && cfg[6]) `CHK("neg slow", 1'b1, chg)
        if (cfg[2:0] != 3'h5) `CHK("pos toggles", !eh, rises != r0)
    endtask : halt_chk
    task automatic step(input int k, input bit en, input bit arm);
        int unsigned tr, n0;
        int i;
        apb(1'b1, ochps_pkg::PHASE_OFS_OFS, {24'h0, 8'(k)});
        apb(1'b1, ochps_pkg::CFG_OFS, {24'h0, en, 7'h04});
        if (arm) apb(1'b1, ochps_pkg::STATUS_OFS, 32'h1);
        repeat (4 * HC) @(posedge pclk);
        tr = last_rise;
        n0 = rises;
        watch <= 1'b1;
        pulse();
        i = 0;
        do begin
            apb(1'b0, ochps_pkg::STATUS_OFS, 32'h0);
            i++;
        end while (rdat[ochps_pkg::ST_DONE_POS] !== 1'b1 && i < (arm ? 400 : 8));
        `CHK("done", arm, rdat[ochps_pkg::ST_DONE_POS])
        repeat (4 * HC) @(posedge pclk);
        `CHK("shift", shift(k, en, arm), int'(last_rise - tr) - int'(rises - n0) * 2 * HC)
        watch <= 1'b0;
        apb(1'b1, ochps_pkg::STATUS_OFS, 32'h2);
    endtask : step
    initial begin
        void'($urandom(32'h0048));
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            apb(1'b0, ochps_pkg::HALT_CTRL_OFS + 12'(4 * i), 32'h0);
            `CHK("reset value", {24'h0, ochps_pkg::REG_RESET}, rdat)
        end
        apb(1'b0, 12'h3fc, 32'h0);
        `CHK("unmapped", 1'b1, rerr)
        repeat (3) begin
            d = $urandom;
            apb(1'b1, ochps_pkg::PHASE_OFS_OFS, d);
            apb(1'b0, ochps_pkg::PHASE_OFS_OFS, 32'h0);
            `CHK("offset rw", {24'h0, d[7:0]}, rdat)
        end
        apb(1'b1, ochps_pkg::SLOW_DIV_OFS, 32'h1);
        for (int v = 0; v < 2; v++) begin
            for (int n = 0; n < 4; n++) begin
                int m;
                // Modes 1, 0, 2, 3: a release always sits between halt high and halt low
                m = n ^ (n >> 1) ^ 1;
                halt_chk({6'h20, 2'(m)}, {2'h0, 1'(v), 5'h04}, m == 1 || m == 2, 1'((m == 1) ^ v));
            end
        end
        for (int f = 1; f < 8; f++) halt_chk(8'h81, 8'(f), 1'b1, 1'b1);
        halt_chk(8'h82, 8'h14, 1'b1, 1'b0);
        halt_chk(8'h81, 8'h44, 1'b1, 1'b1);
        halt_chk(8'h01, 8'h04, 1'b0, 1'b0);
        for (int g = 0; g < 4; g++) begin
            gpio <= 4'(1 << g);
            halt_chk({2'h0, 4'(8 + g), 2'h2}, 8'h04, 1'b1, 1'b0);
            gpio <= 4'($urandom) & ~4'(1 << g);
            halt_chk({2'h0, 4'(8 + g), 2'h2}, 8'h04, 1'b0, 1'b0);
        end
        apb(1'b1, ochps_pkg::HALT_CTRL_OFS, 32'h05);
        apb(1'b1, ochps_pkg::STATUS_OFS, 32'h1);
        repeat (6 * HC) @(posedge pclk);
        apb(1'b0, ochps_pkg::STATUS_OFS, 32'h0);
        `CHK("adjust_flag_a halt", 1'b1, rdat[ochps_pkg::ST_HALTED_POS])
        pulse();
        repeat (6 * HC) @(posedge pclk);
        apb(1'b0, ochps_pkg::STATUS_OFS, 32'h0);
        `CHK("done resume", 1'b0, rdat[ochps_pkg::ST_HALTED_POS])
        apb(1'b1, ochps_pkg::STATUS_OFS, 32'h2);
        chosen_reference <= 1'b0;
        halt_chk(8'h01, 8'h0c, 1'b1, 1'b1);
        chosen_reference <= 1'b1;
        halt_chk(8'h01, 8'h0c, 1'b0, 1'b0);
        step(2, 1'b1, 1'b1);
        step(-3, 1'b1, 1'b1);
        step(63, 1'b1, 1'b1);
        step(-64, 1'b1, 1'b1);
        step(5, 1'b0, 1'b1);
        step(7, 1'b1, 1'b0);
        step(int'($signed(8'($urandom))), 1'b1, 1'b1);
        `CHK("min pulse", 1'b1, min_run >= HC / 2)
        complete_run();
    end
endmodule : ochps_top_tb
